//--- shared/viod_pkg.sv
package viod_pkg;
  // widths of the user side
  localparam int OUT_W = 8;
  localparam int ASY_W = 4;
  localparam int IN_W = 8;
  localparam int TRAIN_LEN = 16;
  localparam logic [3:0] TRAIN_LAST = 4'hF;
  // link frame: op, index, data, shifted lsb first
  localparam int FRAME_W = 24;
  localparam logic [4:0] FRAME_CNT = 5'h18;
  localparam logic [4:0] FRAME_LAST = 5'h17;
  localparam int OP_LSB = 0;
  localparam int OP_MSB = 3;
  localparam int IDX_LSB = 4;
  localparam int IDX_MSB = 7;
  localparam int DAT_LSB = 8;
  localparam int DAT_MSB = 23;
  // read answer layout
  localparam int VAL_LSB = 0;
  localparam int RISE_LSB = 8;
  localparam int FALL_LSB = 16;
  // link clock made by the host: 4 + 4 cycles of 10 ns = 80 ns
  localparam logic [2:0] HALF_LAST = 3'h3;
  localparam logic [2:0] GAP_LAST = 3'h7;
  // host register map, byte addresses
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_RESP = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0C;
  localparam logic [4:0] REG_POLL = 5'h10;
  localparam int ST_DONE = 0;
  localparam int ST_RESP = 1;
  // input polling
  localparam int CLK_KHZ = 100000;
  localparam int POLL_MS = 250;
  localparam int POLL_CYC = POLL_MS * CLK_KHZ / 1000;
  localparam logic [2:0] POLL_MANUAL = 3'h4;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_SET_SYNC,
    OP_SET_ASYNC,
    OP_WR_TRAIN,
    OP_RUN,
    OP_PULSE,
    OP_RESET_ALL,
    OP_READ,
    OP_CLEAR_ACT,
    OP_TOGGLE,
    OP_FILL,
    OP_UPDATE_ALL
  } viod_op_t;

  function automatic logic [FRAME_W-1:0] pack_frame(input logic [3:0] op,
                                                    input logic [3:0] idx,
                                                    input logic [15:0] data);
    return {data, idx, op};
  endfunction
endpackage

//--- shared/viod_link_if.sv
interface viod_link_if;
  logic lclk;
  logic lsel;
  logic ld_h2d;
  logic ld_d2h;

  modport dev (
    input lclk,
    input lsel,
    input ld_h2d,
    output ld_d2h
  );

  modport host (
    output lclk,
    output lsel,
    output ld_h2d,
    input ld_d2h
  );
endinterface

//--- src/viod_dev.sv
// Operation
// - sixteen stored per-cycle values per output bit
// - pulse trains only on clock-synchronous outputs
// - run plays sixteen values once, no repeat
// - host preloads train with last commanded sync level
// - single pulse: exactly one high cycle
// - push button: active level while held
// - toggle inverts commanded level each activation
// - host accepts only legal value encodings; the host refuses only op codes above OP_UPDATE_ALL and masks values
// - host polls inputs periodically or on request
// - changes sent at once; update-all skips trains
// - reset-all zeroes levels and all train entries
// - clear-activity discards all recorded input activity
// - samples carry change-since-last-query activity
// - synchronous rise and fall reported separately
module viod_dev (
  input wire logic i_clk,
  input wire logic i_srst,
  viod_link_if.dev link,
  input wire logic [viod_pkg::IN_W-1:0] i_user_in,
  output logic [viod_pkg::OUT_W-1:0] o_sync_out,
  output logic [viod_pkg::ASY_W-1:0] o_async_out
);
  logic [1:0] lclk_m;
  logic [1:0] lsel_m;
  logic [1:0] ldi_m;
  logic lclk_q;
  logic lsel_q;
  logic lclk_rise;
  logic lclk_fall;
  logic sel_rise;
  logic sel_fall;
  logic [viod_pkg::FRAME_W-1:0] rx_sr;
  logic [viod_pkg::FRAME_W-1:0] tx_sr;
  logic [4:0] bit_cnt;
  logic cmd_go;
  logic [3:0] cmd_op;
  logic [3:0] cmd_idx;
  logic [viod_pkg::OUT_W-1:0] cmd_data;
  logic [viod_pkg::OUT_W-1:0] train [viod_pkg::TRAIN_LEN];
  logic running;
  logic [3:0] step;
  logic [viod_pkg::OUT_W-1:0] level;
  logic [viod_pkg::OUT_W-1:0] pulse;
  logic [viod_pkg::OUT_W-1:0] next_sync_out;
  logic [viod_pkg::IN_W-1:0] in_m1;
  logic [viod_pkg::IN_W-1:0] in_m2;
  logic [viod_pkg::IN_W-1:0] in_q;
  logic [viod_pkg::IN_W-1:0] rise_new;
  logic [viod_pkg::IN_W-1:0] fall_new;
  logic [viod_pkg::IN_W-1:0] rise_acc;
  logic [viod_pkg::IN_W-1:0] fall_acc;

  function automatic logic cmd_is(input logic go, input logic [3:0] op,
                                  input viod_pkg::viod_op_t want);
    return go && (op == 4'(want));
  endfunction

  // link pins come from another clock: two flops before any use
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      lclk_m <= 2'h0;
      lsel_m <= 2'h0;
      ldi_m <= 2'h0;
      lclk_q <= 1'b0;
      lsel_q <= 1'b0;
    end
    else
    begin
      lclk_m <= {lclk_m[0], link.lclk};
      lsel_m <= {lsel_m[0], link.lsel};
      ldi_m <= {ldi_m[0], link.ld_h2d};
      lclk_q <= lclk_m[1];
      lsel_q <= lsel_m[1];
    end
  end

  assign lclk_rise = lclk_m[1] && !lclk_q;
  assign lclk_fall = !lclk_m[1] && lclk_q;
  assign sel_rise = lsel_m[1] && !lsel_q;
  assign sel_fall = !lsel_m[1] && lsel_q;

  // frame receiver; a frame of the wrong length is dropped
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rx_sr <= '0;
      bit_cnt <= 5'h00;
    end
    else if (sel_rise)
    begin
      bit_cnt <= 5'h00;
    end
    else if (lsel_m[1] && lclk_rise)
    begin
      rx_sr <= {ldi_m[1], rx_sr[viod_pkg::FRAME_W-1:1]};
      if (bit_cnt != 5'h1F)
      begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  assign cmd_go = sel_fall && (bit_cnt == viod_pkg::FRAME_CNT);
  assign cmd_op = rx_sr[viod_pkg::OP_MSB:viod_pkg::OP_LSB];
  assign cmd_idx = rx_sr[viod_pkg::IDX_MSB:viod_pkg::IDX_LSB];
  assign cmd_data = rx_sr[viod_pkg::DAT_LSB +: viod_pkg::OUT_W];

  // train store, one word per cycle, one bit per output
  always_ff @(posedge i_clk)
  begin
    if (i_srst || cmd_is(cmd_go, cmd_op, viod_pkg::OP_RESET_ALL))
    begin
      for (int i = 0; i < viod_pkg::TRAIN_LEN; i++)
      begin
        train[i] <= '0;
      end
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_WR_TRAIN))
    begin
      train[cmd_idx] <= cmd_data;
    end
  end

  // player: one pass only, no wrap
  always_ff @(posedge i_clk)
  begin
    if (i_srst || cmd_is(cmd_go, cmd_op, viod_pkg::OP_RESET_ALL))
    begin
      running <= 1'b0;
      step <= 4'h0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_RUN))
    begin
      running <= 1'b1;
      step <= 4'h0;
    end
    else if (running)
    begin
      step <= step + 4'h1;
      if (step == viod_pkg::TRAIN_LAST)
      begin
        running <= 1'b0;
      end
    end
  end

  // static level; push and toggle buttons are host-driven levels
  always_ff @(posedge i_clk)
  begin
    if (i_srst || cmd_is(cmd_go, cmd_op, viod_pkg::OP_RESET_ALL))
    begin
      level <= '0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_SET_SYNC))
    begin
      level <= cmd_data;
    end
    else if (running && step == viod_pkg::TRAIN_LAST)
    begin
      level <= train[viod_pkg::TRAIN_LAST];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      pulse <= '0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_PULSE))
    begin
      pulse <= viod_pkg::OUT_W'(1) << cmd_idx[2:0];
    end
    else
    begin
      pulse <= '0;
    end
  end

  assign next_sync_out = running ? train[step] : (level | pulse);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_sync_out <= '0;
    end
    else
    begin
      o_sync_out <= next_sync_out;
    end
  end

  // async outputs: static level only, no train or pulse path
  always_ff @(posedge i_clk)
  begin
    if (i_srst || cmd_is(cmd_go, cmd_op, viod_pkg::OP_RESET_ALL))
    begin
      o_async_out <= '0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_SET_ASYNC))
    begin
      o_async_out <= cmd_data[viod_pkg::ASY_W-1:0];
    end
  end

  // user inputs, sampled on the design clock
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      in_m1 <= '0;
      in_m2 <= '0;
      in_q <= '0;
    end
    else
    begin
      in_m1 <= i_user_in;
      in_m2 <= in_m1;
      in_q <= in_m2;
    end
  end

  assign rise_new = in_m2 & ~in_q;
  assign fall_new = ~in_m2 & in_q;

  // an edge in the clearing cycle survives into the next window
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      rise_acc <= '0;
      fall_acc <= '0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_READ) ||
             cmd_is(cmd_go, cmd_op, viod_pkg::OP_CLEAR_ACT))
    begin
      rise_acc <= rise_new;
      fall_acc <= fall_new;
    end
    else
    begin
      rise_acc <= rise_acc | rise_new;
      fall_acc <= fall_acc | fall_new;
    end
  end

  // answer goes out during the next frame, changed on link falls
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tx_sr <= '0;
      link.ld_d2h <= 1'b0;
    end
    else if (cmd_is(cmd_go, cmd_op, viod_pkg::OP_READ))
    begin
      tx_sr <= {fall_acc | fall_new, rise_acc | rise_new, in_m2};
      link.ld_d2h <= in_m2[0];
    end
    else if (lsel_m[1] && lclk_fall)
    begin
      tx_sr <= {1'b0, tx_sr[viod_pkg::FRAME_W-1:1]};
      link.ld_d2h <= tx_sr[1];
    end
  end
endmodule

//--- src/viod_host.sv
module viod_host #(
  parameter int POLL_CYC = viod_pkg::POLL_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  viod_link_if.host link
);
  typedef enum {LK_IDLE, LK_LOW, LK_HIGH, LK_GAP} viod_lk_t;

  viod_lk_t lk_state;
  logic [2:0] div;
  logic [4:0] bit_no;
  logic [viod_pkg::FRAME_W-1:0] tx_sr;
  logic [viod_pkg::FRAME_W-1:0] rx_sr;
  logic [1:0] dh_m;
  logic busy;
  logic [3:0] job_op;
  logic [3:0] job_idx;
  logic [15:0] job_data;
  logic [4:0] frame_no;
  logic [4:0] frames_last;
  logic frame_end;
  logic job_done;
  logic [viod_pkg::OUT_W-1:0] shadow_sync;
  logic [viod_pkg::ASY_W-1:0] shadow_async;
  logic [viod_pkg::FRAME_W-1:0] resp;
  logic [1:0] status;
  logic [1:0] mask;
  logic [2:0] poll_sel;
  logic [31:0] poll_cnt;
  logic poll_due;
  logic cmd_wr_pend;
  logic stall;
  logic acc;
  logic acc_wr_cmd;
  logic [3:0] wr_op;
  logic [viod_pkg::FRAME_W-1:0] next_frame;

  assign cmd_wr_pend = i_avs_write && (i_avs_address == viod_pkg::REG_CMD);
  assign stall = cmd_wr_pend && busy;
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign acc_wr_cmd = acc && cmd_wr_pend;
  assign wr_op = i_avs_writedata[viod_pkg::OP_MSB:viod_pkg::OP_LSB];

  // answer one cycle after the request; commands wait while busy
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest && !stall);
      case (i_avs_address)
        viod_pkg::REG_CMD: o_avs_readdata <= {31'h0000_0000, busy};
        viod_pkg::REG_RESP: o_avs_readdata <= {8'h00, resp};
        viod_pkg::REG_STATUS: o_avs_readdata <= {30'h0000_0000, status};
        viod_pkg::REG_MASK: o_avs_readdata <= {30'h0000_0000, mask};
        viod_pkg::REG_POLL: o_avs_readdata <= {29'h0000_0000, poll_sel};
        default: o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // periodic input read; manual leaves reads to READ commands
  assign poll_due = (poll_sel != viod_pkg::POLL_MANUAL) &&
                    (poll_cnt >= (32'(POLL_CYC) << poll_sel[1:0]) - 32'h1);
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      poll_sel <= 3'h0;
      poll_cnt <= 32'h0000_0000;
    end
    else
    begin
      if (acc && i_avs_write && i_avs_address == viod_pkg::REG_POLL)
      begin
        poll_sel <= (i_avs_writedata[2:0] > viod_pkg::POLL_MANUAL) ?
                    viod_pkg::POLL_MANUAL : i_avs_writedata[2:0];
      end
      if (poll_due && !busy && !cmd_wr_pend)
      begin
        poll_cnt <= 32'h0000_0000;
      end
      else if (!poll_due)
      begin
        poll_cnt <= poll_cnt + 32'h1;
      end
    end
  end

  // job intake and shadow of the commanded levels
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      busy <= 1'b0;
      job_op <= 4'h0;
      job_idx <= 4'h0;
      job_data <= 16'h0000;
      frames_last <= 5'h00;
      shadow_sync <= '0;
      shadow_async <= '0;
    end
    else if (acc_wr_cmd && wr_op <= 4'(viod_pkg::OP_UPDATE_ALL))
    begin
      busy <= 1'b1;
      job_op <= wr_op;
      job_idx <= i_avs_writedata[viod_pkg::IDX_MSB:viod_pkg::IDX_LSB];
      // value fields are plain binary, masked to the target width
      job_data <= {8'h00, i_avs_writedata[viod_pkg::DAT_LSB +: viod_pkg::OUT_W]};
      case (viod_pkg::viod_op_t'(wr_op))
        viod_pkg::OP_READ: frames_last <= 5'h01;
        viod_pkg::OP_UPDATE_ALL: frames_last <= 5'h01;
        viod_pkg::OP_FILL: frames_last <= 5'(viod_pkg::TRAIN_LAST);
        default: frames_last <= 5'h00;
      endcase
      case (viod_pkg::viod_op_t'(wr_op))
        viod_pkg::OP_SET_SYNC:
          shadow_sync <= i_avs_writedata[viod_pkg::DAT_LSB +: viod_pkg::OUT_W];
        viod_pkg::OP_SET_ASYNC:
          shadow_async <= i_avs_writedata[viod_pkg::DAT_LSB +: viod_pkg::ASY_W];
        viod_pkg::OP_TOGGLE:
          shadow_sync[i_avs_writedata[6:4]] <= !shadow_sync[i_avs_writedata[6:4]];
        viod_pkg::OP_RESET_ALL:
        begin
          shadow_sync <= '0;
          shadow_async <= '0;
        end
        default:
        begin
        end
      endcase
    end
    else if (poll_due && !busy && !cmd_wr_pend)
    begin
      busy <= 1'b1;
      job_op <= 4'(viod_pkg::OP_READ);
      frames_last <= 5'h01;
    end
    else if (job_done)
    begin
      busy <= 1'b0;
    end
  end

  // one job becomes one or more link frames
  always_comb
  begin
    case (viod_pkg::viod_op_t'(job_op))
      viod_pkg::OP_READ:
        next_frame = viod_pkg::pack_frame((frame_no == 5'h00) ? 4'(viod_pkg::OP_READ) :
                                          4'(viod_pkg::OP_NOP), 4'h0, 16'h0000);
      viod_pkg::OP_TOGGLE:
        next_frame = viod_pkg::pack_frame(4'(viod_pkg::OP_SET_SYNC), 4'h0,
                                          16'(shadow_sync));
      viod_pkg::OP_FILL:
        next_frame = viod_pkg::pack_frame(4'(viod_pkg::OP_WR_TRAIN), frame_no[3:0],
                                          16'(shadow_sync));
      viod_pkg::OP_UPDATE_ALL:
        next_frame = (frame_no == 5'h00) ?
          viod_pkg::pack_frame(4'(viod_pkg::OP_SET_SYNC), 4'h0, 16'(shadow_sync)) :
          viod_pkg::pack_frame(4'(viod_pkg::OP_SET_ASYNC), 4'h0, 16'(shadow_async));
      default:
        next_frame = viod_pkg::pack_frame(job_op, job_idx, job_data);
    endcase
  end

  assign frame_end = (lk_state == LK_GAP) && (div == viod_pkg::GAP_LAST);
  assign job_done = frame_end && (frame_no == frames_last);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      dh_m <= 2'h0;
    end
    else
    begin
      dh_m <= {dh_m[0], link.ld_d2h};
    end
  end

  // link clock divided from i_clk; data changes while it is low
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      lk_state <= LK_IDLE;
      div <= 3'h0;
      bit_no <= 5'h00;
      frame_no <= 5'h00;
      tx_sr <= '0;
      rx_sr <= '0;
      link.lclk <= 1'b0;
      link.lsel <= 1'b0;
      link.ld_h2d <= 1'b0;
    end
    else
    begin
      div <= div + 3'h1;
      case (lk_state)
        LK_IDLE:
        begin
          div <= 3'h0;
          if (busy)
          begin
            tx_sr <= next_frame;
            link.ld_h2d <= next_frame[0];
            link.lsel <= 1'b1;
            bit_no <= 5'h00;
            lk_state <= LK_LOW;
          end
        end
        LK_LOW:
        begin
          if (div == viod_pkg::HALF_LAST)
          begin
            div <= 3'h0;
            link.lclk <= 1'b1;
            lk_state <= LK_HIGH;
          end
        end
        LK_HIGH:
        begin
          if (div == viod_pkg::HALF_LAST)
          begin
            div <= 3'h0;
            link.lclk <= 1'b0;
            rx_sr <= {dh_m[1], rx_sr[viod_pkg::FRAME_W-1:1]};
            tx_sr <= {1'b0, tx_sr[viod_pkg::FRAME_W-1:1]};
            link.ld_h2d <= tx_sr[1];
            bit_no <= bit_no + 5'h01;
            if (bit_no == viod_pkg::FRAME_LAST)
            begin
              link.lsel <= 1'b0;
              lk_state <= LK_GAP;
            end
            else
            begin
              lk_state <= LK_LOW;
            end
          end
        end
        LK_GAP:
        begin
          if (div == viod_pkg::GAP_LAST)
          begin
            frame_no <= (frame_no == frames_last) ? 5'h00 : frame_no + 5'h01;
            lk_state <= LK_IDLE;
          end
        end
        default: lk_state <= LK_IDLE;
      endcase
    end
  end

  // answer copy, status, mask and interrupt
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      resp <= '0;
      status <= 2'h0;
      mask <= 2'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      if (job_done && job_op == 4'(viod_pkg::OP_READ))
      begin
        resp <= rx_sr;
      end
      else if (acc_wr_cmd && wr_op == 4'(viod_pkg::OP_CLEAR_ACT))
      begin
        resp[viod_pkg::FALL_LSB +: viod_pkg::IN_W] <= '0;
        resp[viod_pkg::RISE_LSB +: viod_pkg::IN_W] <= '0;
      end
      if (acc && i_avs_write && i_avs_address == viod_pkg::REG_MASK)
      begin
        mask <= i_avs_writedata[1:0];
      end
      // set wins over a write-one clear in the same cycle
      status <= (status & ~((acc && i_avs_write && i_avs_address == viod_pkg::REG_STATUS) ?
                            i_avs_writedata[1:0] : 2'h0)) |
                {job_done && job_op == 4'(viod_pkg::OP_READ), job_done};
      o_irq <= |(status & mask);
    end
  end
endmodule

//--- tb/viod_monitor.sv
module viod_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_lclk,
  input wire logic i_lsel,
  input wire logic i_ld_h2d,
  input wire logic i_ld_d2h
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lclk_q;
  logic [5:0] n_rise;
  // rises of the link clock inside the current frame
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !i_lsel)
    begin
      n_rise <= 6'h00;
    end
    else if (i_lclk && !lclk_q)
    begin
      n_rise <= n_rise + 6'h01;
    end
  end
  always_ff @(posedge i_clk)
  begin
    lclk_q <= i_srst ? 1'b0 : i_lclk;
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  idle_clock_a: assert property (!i_lsel |-> !i_lclk)
    else $error("link clock moves outside a frame");
  clock_high_a: assert property ($rose(i_lclk) |-> i_lclk [*4] ##1 !i_lclk)
    else $error("link clock high phase is not four cycles");
  clock_low_a: assert property ($fell(i_lclk) |-> !i_lclk [*4])
    else $error("link clock low phase shorter than four cycles");
  frame_start_a: assert property ($rose(i_lsel) |-> !i_lclk [*3] ##[1:6] i_lclk)
    else $error("frame does not open with a low phase");
  frame_bits_a: assert property ($fell(i_lsel) |-> n_rise == 6'h18)
    else $error("frame closed without 24 clock rises");
  frame_gap_a: assert property ($fell(i_lsel) |-> !i_lsel [*8])
    else $error("frame gap shorter than eight cycles");
  cmd_hold_a: assert property (i_lsel && i_lclk && $past(i_lclk) |-> $stable(i_ld_h2d))
    else $error("command bit moved while link clock high");
  answer_hold_a: assert property (i_lclk && $past(i_lclk) |-> $stable(i_ld_d2h))
    else $error("answer bit moved while link clock high");
endmodule

//--- tb/viod_test.sv
module viod_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [4:0] av_addr = 5'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h00000000;
  logic [31:0] av_rdata;
  logic av_wait;
  logic irq;
  logic [7:0] uin = 8'h00;
  logic [7:0] sync_out;
  logic [3:0] async_out;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int hits;
  logic rec = 1'b0;
  logic [7:0] rec_q[$];
  logic [7:0] train[16];
  logic [7:0] exp_sync = 8'h00;
  logic [3:0] exp_async = 4'h0;
  logic [1:0] mask_v = 2'b00;
  logic [31:0] rd;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] m;
  logic [2:0] ix;
  viod_link_if link_bus();
  // short poll period keeps the periodic read within reach of the run
  viod_host #(.POLL_CYC(200)) i_viod_host (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_avs_address(av_addr),
    .i_avs_read(av_rd),
    .i_avs_write(av_wr),
    .i_avs_writedata(av_wd),
    .o_avs_readdata(av_rdata),
    .o_avs_waitrequest(av_wait),
    .o_irq(irq),
    .link(link_bus.host)
  );
  viod_dev i_viod_dev (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .link(link_bus.dev),
    .i_user_in(uin),
    .o_sync_out(sync_out),
    .o_async_out(async_out)
  );
  viod_monitor i_viod_monitor (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_lclk(link_bus.lclk),
    .i_lsel(link_bus.lsel),
    .i_ld_h2d(link_bus.ld_h2d),
    .i_ld_d2h(link_bus.ld_d2h)
  );
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (rec)
      rec_q.push_back(sync_out);
    if (cycles == 60000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
      $display("CHECK FAILED %0t: %s got %h expected %h", $time, what, got, exp);
    if (got !== exp)
      n_fail++;
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    av_addr <= ad;
    av_wr <= wr;
    av_rd <= !wr;
    av_wd <= d;
    @(posedge i_clk);
    while (av_wait !== 1'b0)
      @(posedge i_clk);
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [3:0] ixx, input logic [7:0] v);
    logic [1:0] want;
    want = (op == viod_pkg::OP_READ) ? 2'b10 : 2'b01;
    xfer(1'b1, viod_pkg::REG_CMD, {16'h0000, v, ixx, op});
    rd = 32'h00000000;
    while ((rd[1:0] & want) !== want)
      xfer(1'b0, viod_pkg::REG_STATUS, 32'h00000000);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, {31'h0, |(rd[1:0] & mask_v)}, "irq raised");
    xfer(1'b1, viod_pkg::REG_STATUS, 32'h00000003);
    repeat (2) @(posedge i_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  // output change lands a few cycles after the frame
  task automatic settle();
    int n;
    n = 0;
    while ((sync_out !== exp_sync || async_out !== exp_async) && n < 40)
    begin
      @(posedge i_clk);
      n++;
    end
    chk({24'h0, sync_out}, {24'h0, exp_sync}, "sync level");
    chk({28'h0, async_out}, {28'h0, exp_async}, "async level");
  endtask
  task automatic play(input logic [3:0] op, input logic [3:0] ixx);
    rec_q.delete();
    rec <= 1'b1;
    cmd(op, ixx, 8'h00);
    repeat (40) @(posedge i_clk);
    rec <= 1'b0;
  endtask
  function automatic logic all_eq(input logic [7:0] v);
    all_eq = rec_q.size() > 0;
    foreach (rec_q[i])
      all_eq &= rec_q[i] === v;
  endfunction
  task automatic rdin(input logic [23:0] e);
    cmd(viod_pkg::OP_READ, 4'h0, 8'h00);
    xfer(1'b0, viod_pkg::REG_RESP, 32'h00000000);
    chk(rd, {8'h00, e}, "input sample");
  endtask
  initial
  begin
    int s;
    logic ok;
    void'($urandom(32'h56D4A79F));
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    chk({20'h0, sync_out, async_out}, 32'h0, "reset outputs");
    xfer(1'b0, viod_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0, "status reset");
    xfer(1'b0, viod_pkg::REG_POLL, 32'h0);
    chk(rd, 32'h0, "poll reset");
    xfer(1'b1, 5'h14, 32'hFFFFFFFF);
    xfer(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    xfer(1'b0, viod_pkg::REG_MASK, 32'h0);
    chk(rd, 32'h0, "mask untouched");
    repeat (800) @(posedge i_clk);
    xfer(1'b0, viod_pkg::REG_STATUS, 32'h0);
    chk({31'h0, rd[1]}, 32'h1, "periodic read");
    xfer(1'b1, viod_pkg::REG_POLL, 32'h4);
    xfer(1'b0, viod_pkg::REG_POLL, 32'h0);
    chk(rd, 32'h4, "poll manual");
    // a poll in flight may still land, so wait it out before clearing
    repeat (600) @(posedge i_clk);
    xfer(1'b1, viod_pkg::REG_STATUS, 32'h3);
    xfer(1'b1, viod_pkg::REG_MASK, 32'h1);
    mask_v = 2'b01;
    cmd(viod_pkg::OP_NOP, 4'h0, 8'h00);
    settle();
    a = 8'($urandom);
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, a);
    exp_sync = a;
    settle();
    ix = 3'($urandom);
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, exp_sync ^ (8'h01 << ix));
    exp_sync ^= 8'h01 << ix;
    settle();
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, exp_sync ^ (8'h01 << ix));
    exp_sync ^= 8'h01 << ix;
    settle();
    a = 8'($urandom);
    cmd(viod_pkg::OP_SET_ASYNC, 4'h0, {4'h0, a[3:0]});
    exp_async = a[3:0];
    settle();
    repeat (2)
    begin
      ix = 3'($urandom);
      cmd(viod_pkg::OP_TOGGLE, {1'b0, ix}, 8'h00);
      exp_sync ^= 8'h01 << ix;
      settle();
    end
    cmd(viod_pkg::OP_UPDATE_ALL, 4'h0, 8'h00);
    settle();
    xfer(1'b1, viod_pkg::REG_MASK, 32'h0);
    mask_v = 2'b00;
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, 8'h00);
    exp_sync = 8'h00;
    settle();
    ix = 3'($urandom);
    play(viod_pkg::OP_PULSE, {1'b0, ix});
    hits = 0;
    ok = 1'b1;
    foreach (rec_q[i])
    begin
      hits += int'(rec_q[i] === 8'h01 << ix);
      ok &= rec_q[i] === 8'h00 || rec_q[i] === 8'h01 << ix;
    end
    chk({31'h0, ok}, 32'h1, "pulse shape");
    chk(hits, 1, "pulse length");
    for (int k = 0; k < 16; k++)
    begin
      train[k] = {4'($urandom), 4'(k)};
      cmd(viod_pkg::OP_WR_TRAIN, 4'(k), train[k]);
    end
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, 8'h5F);
    exp_sync = 8'h5F;
    settle();
    play(viod_pkg::OP_RUN, 4'h0);
    s = -1;
    foreach (rec_q[i])
      if (s < 0 && rec_q[i] === train[0])
        s = i;
    ok = s >= 0 && rec_q.size() > s + 16;
    for (int k = 0; ok && s + k < rec_q.size(); k++)
      ok &= rec_q[s + k] === train[k < 16 ? k : 15];
    chk({31'h0, ok}, 32'h1, "train played once");
    exp_sync = train[15];
    repeat (100) @(posedge i_clk);
    settle();
    a = 8'($urandom);
    cmd(viod_pkg::OP_SET_SYNC, 4'h0, a);
    exp_sync = a;
    settle();
    cmd(viod_pkg::OP_FILL, 4'h0, 8'h00);
    play(viod_pkg::OP_RUN, 4'h0);
    chk({31'h0, all_eq(a)}, 32'h1, "filled train");
    cmd(viod_pkg::OP_RESET_ALL, 4'h0, 8'h00);
    exp_sync = 8'h00;
    exp_async = 4'h0;
    settle();
    play(viod_pkg::OP_RUN, 4'h0);
    chk({31'h0, all_eq(8'h00)}, 32'h1, "cleared train");
    a = 8'($urandom);
    uin <= a;
    repeat (5) @(posedge i_clk);
    cmd(viod_pkg::OP_READ, 4'h0, 8'h00);
    b = 8'($urandom);
    uin <= b;
    repeat (5) @(posedge i_clk);
    rdin({a & ~b, b & ~a, b});
    m = 8'($urandom) | 8'h01;
    uin <= b ^ m;
    @(posedge i_clk);
    uin <= b;
    repeat (5) @(posedge i_clk);
    rdin({m, m, b});
    uin <= b ^ m;
    @(posedge i_clk);
    uin <= b;
    repeat (5) @(posedge i_clk);
    cmd(viod_pkg::OP_CLEAR_ACT, 4'h0, 8'h00);
    xfer(1'b0, viod_pkg::REG_RESP, 32'h00000000);
    chk(rd, {24'h000000, b}, "cleared answer copy");
    rdin({16'h0000, b});
    xfer(1'b1, viod_pkg::REG_CMD, 32'h0000FF0F);
    xfer(1'b0, viod_pkg::REG_CMD, 32'h00000000);
    chk(rd, 32'h0, "refused op busy");
    chk({24'h0, sync_out}, 32'h0, "refused op level");
    print_verdict();
  end
endmodule
